//--- hdl/dl_pkg.sv
package dl_pkg;
   // Host register offsets (byte addresses on the host I/O port)
   localparam logic [3:0] OFF_DATA_LO = 4'h0;
   localparam logic [3:0] OFF_DATA_HI = 4'h1;
   localparam logic [3:0] OFF_DATAINC_LO = 4'h2;
   localparam logic [3:0] OFF_DATAINC_HI = 4'h3;
   localparam logic [3:0] OFF_ADDR_LO = 4'h4;
   localparam logic [3:0] OFF_ADDR_HI = 4'h5;
   localparam logic [3:0] OFF_INT_LO = 4'h6;
   localparam logic [3:0] OFF_INT_HI = 4'h7;
   localparam logic [3:0] OFF_CTRL2 = 4'hF;
   // Interrupt register values
   localparam logic [15:0] INT_DIAG_OK = 16'h0040;
   localparam logic [15:0] INT_DL_REQ = 16'h8000;
   localparam logic [15:0] INT_RESET = 16'h0000;
   // Freeze-dump commands, written to the interrupt high byte
   localparam logic [7:0] CMD_WRITE = 8'hE6;
   localparam logic [7:0] CMD_STEP = 8'hFF;
   localparam logic [7:0] CMD_EXECUTE = 8'hC5;
   // Control byte bit that disables the handler ROM
   localparam int HRD_BIT = 6;
   // ROM window remapped to DRAM
   localparam logic [15:0] ROM_LO = 16'hC000;
   localparam logic [15:0] ROM_HI = 16'hFFFE;
   // Timing
   localparam int CLK_MHZ = 50;
   localparam int DIAG_NS = 2000;
   localparam int REQ_WIN_US10 = 16;
   localparam int WRITE_US = 9;
   localparam int STEP_US = 7;
   localparam int EXEC_US = 12;
   localparam int DIAG_CYC = DIAG_NS * CLK_MHZ / 1000;
   localparam int REQ_WIN_CYC = REQ_WIN_US10 * 100 * CLK_MHZ;
   localparam int WRITE_CYC = WRITE_US * CLK_MHZ;
   localparam int STEP_CYC = STEP_US * CLK_MHZ;
   localparam int EXEC_CYC = EXEC_US * CLK_MHZ;
   localparam int CNT_W = 17;
   typedef enum logic [4:0] {
      ST_DIAG = 5'h01,
      ST_ARMED = 5'h02,
      ST_NORMAL = 5'h04,
      ST_DOWNLOAD = 5'h08,
      ST_BUSY = 5'h10
   } mode_type;
endpackage

//--- hdl/cmd_timer_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cmd_timer_if;
   logic start;
   logic [16:0] load;
   logic done;
   modport owner (output start, output load, input done);
   modport timer (input start, input load, output done);
endinterface
`default_nettype wire

//--- hdl/cmd_timer.sv
`timescale 1ns/1ns
`default_nettype none
module cmd_timer (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   cmd_timer_if.timer port // Start, length, done pulse
);
   typedef struct packed {
      logic [16:0] count;
      logic running;
      logic done;
   } tstate_type;
   tstate_type s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (port.start) begin
         s_next.count = port.load;
         s_next.running = 1'b1;
      end else if (s_reg.running) begin
         if (s_reg.count <= 17'h00001) begin
            s_next.running = 1'b0;
            s_next.done = 1'b1;
         end else begin
            s_next.count = s_reg.count - 17'h00001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign port.done = s_reg.done;
endmodule
`default_nettype wire

//--- hdl/adapter_code_download_entry.sv
`timescale 1ns/1ns
`default_nettype none
module adapter_code_download_entry #(
   parameter int REQ_WINDOW = dl_pkg::REQ_WIN_CYC, // Cycles the request is accepted
   parameter int DIAG_TIME = dl_pkg::DIAG_CYC // Cycles of bring-up diagnostics
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic system_reset_n, // Host hardware reset pin
   input wire logic ioWrite, // Host direct I/O write strobe (pin)
   input wire logic ioRead, // Host direct I/O read strobe (pin)
   input wire logic [3:0] ioAddr, // Host direct I/O byte offset
   input wire logic [7:0] ioWdata, // Host write data
   output logic [7:0] ioRdata, // Read data, registered
   output logic memWrite, // One-cycle RAM write pulse
   output logic [15:0] memAddr, // RAM word byte address
   output logic [15:0] memWdata, // RAM write data
   output logic handlerRomSelect, // Handler ROM chip select for top window
   output logic dramSelect, // DRAM select for accessed address
   output logic handler_rom_disable, // ROM disable control level
   output logic downloadActive, // Download state entered
   output logic cmdBusy, // Freeze-dump command executing
   output logic runTarget, // Target code started
   output logic [15:0] targetEntry // Entry address for target code
);
   typedef struct packed {
      logic [2:0] rstSync;
      logic [2:0] wrSync;
      logic [2:0] rdSync;
      logic [7:0] addrSync;
      logic [15:0] dataSync;
      dl_pkg::mode_type mode;
      logic [16:0] winCnt;
      logic [15:0] intReg;
      logic [15:0] addr;
      logic [7:0] dataLo;
      logic [7:0] rdata;
      logic memWr;
      logic [15:0] memA;
      logic [15:0] memD;
      logic romDis;
      logic [7:0] pendCmd;
      logic run;
      logic [15:0] entry;
      logic entrySet;
      logic romSel;
      logic dramSel;
      logic dlAct;
      logic busy;
   } state_type;
   state_type s_reg, s_next;
   cmd_timer_if tif ();
   logic wrEdge, rdEdge, hostReset;
   logic [3:0] hostAddr;
   logic [7:0] hostData;
   logic [15:0] accAddr;

   cmd_timer u_timer (
      .clk(clk),
      .rst(rst),
      .port(tif.timer)
   );

   // Pin strobes: two stages of sync, edge from stages 2 and 3 only
   assign wrEdge = s_reg.wrSync[1] & ~s_reg.wrSync[2];
   assign rdEdge = s_reg.rdSync[1] & ~s_reg.rdSync[2];
   assign hostReset = ~s_reg.rstSync[1];
   assign accAddr = s_reg.addr;
   // Offset and data ride the same two-stage path as the strobes
   assign hostAddr = s_reg.addrSync[7:4];
   assign hostData = s_reg.dataSync[15:8];

   always_comb begin
      s_next = s_reg;
      s_next.rstSync = {s_reg.rstSync[1:0], system_reset_n};
      s_next.wrSync = {s_reg.wrSync[1:0], ioWrite};
      s_next.rdSync = {s_reg.rdSync[1:0], ioRead};
      s_next.addrSync = {s_reg.addrSync[3:0], ioAddr};
      s_next.dataSync = {s_reg.dataSync[7:0], ioWdata};
      s_next.memWr = 1'b0;
      tif.start = 1'b0;
      tif.load = '0;
      if (s_reg.winCnt != '0) begin
         s_next.winCnt = s_reg.winCnt - 17'h00001;
      end
      if (hostReset) begin
         // Every host reset arms download entry; RAM contents are kept
         s_next.mode = dl_pkg::ST_DIAG;
         s_next.winCnt = 17'(DIAG_TIME);
         s_next.intReg = dl_pkg::INT_RESET;
         s_next.romDis = 1'b0;
         s_next.run = 1'b0;
         s_next.entrySet = 1'b0;
      end else begin
         case (s_reg.mode)
            dl_pkg::ST_DIAG: begin
               if (s_reg.winCnt == '0) begin
                  s_next.intReg = dl_pkg::INT_DIAG_OK;
                  s_next.mode = dl_pkg::ST_ARMED;
                  s_next.winCnt = 17'(REQ_WINDOW);
               end
            end
            dl_pkg::ST_ARMED: begin
               if (s_reg.winCnt == '0) begin
                  s_next.mode = dl_pkg::ST_NORMAL;
               end
            end
            dl_pkg::ST_NORMAL: begin
            end
            dl_pkg::ST_DOWNLOAD: begin
            end
            dl_pkg::ST_BUSY: begin
               if (tif.done) begin
                  s_next.mode = dl_pkg::ST_DOWNLOAD;
                  if (s_reg.pendCmd == dl_pkg::CMD_EXECUTE) begin
                     s_next.run = 1'b1;
                  end
               end
            end
            default: s_next.mode = dl_pkg::ST_NORMAL;
         endcase
         if (wrEdge) begin
            case (hostAddr)
               dl_pkg::OFF_ADDR_LO: s_next.addr[7:0] = hostData;
               dl_pkg::OFF_ADDR_HI: s_next.addr[15:8] = hostData;
               dl_pkg::OFF_DATA_LO, dl_pkg::OFF_DATAINC_LO: s_next.dataLo = hostData;
               dl_pkg::OFF_DATA_HI, dl_pkg::OFF_DATAINC_HI: begin
                  s_next.memWr = 1'b1;
                  s_next.memA = accAddr;
                  s_next.memD = {hostData, s_reg.dataLo};
                  if (s_reg.mode == dl_pkg::ST_DOWNLOAD && !s_reg.entrySet &&
                      accAddr == 16'h0000 && hostAddr == dl_pkg::OFF_DATA_HI) begin
                     s_next.entry = {hostData, s_reg.dataLo};
                     s_next.entrySet = 1'b1;
                  end
                  if (hostAddr == dl_pkg::OFF_DATAINC_HI) begin
                     s_next.addr = accAddr + 16'h0002;
                  end
               end
               dl_pkg::OFF_INT_LO: s_next.intReg[7:0] = hostData;
               dl_pkg::OFF_INT_HI: begin
                  if (s_reg.mode == dl_pkg::ST_ARMED &&
                      {hostData, s_reg.intReg[7:0]} == dl_pkg::INT_DL_REQ) begin
                     // Only a request inside the window after reset is honoured
                     s_next.mode = dl_pkg::ST_DOWNLOAD;
                     s_next.intReg = 16'h0000;
                  end else if (s_reg.mode == dl_pkg::ST_DOWNLOAD &&
                               (hostData == dl_pkg::CMD_WRITE ||
                                hostData == dl_pkg::CMD_STEP ||
                                hostData == dl_pkg::CMD_EXECUTE)) begin
                     s_next.mode = dl_pkg::ST_BUSY;
                     s_next.pendCmd = hostData;
                     tif.start = 1'b1;
                     // Timer done is acted on one cycle late, so load one less
                     if (hostData == dl_pkg::CMD_WRITE) begin
                        tif.load = 17'(dl_pkg::WRITE_CYC - 1);
                     end else if (hostData == dl_pkg::CMD_STEP) begin
                        tif.load = 17'(dl_pkg::STEP_CYC - 1);
                     end else begin
                        tif.load = 17'(dl_pkg::EXEC_CYC - 1);
                     end
                  end else if (s_reg.mode != dl_pkg::ST_BUSY) begin
                     // Commands during execution are ignored
                     s_next.intReg[15:8] = hostData;
                  end
               end
               dl_pkg::OFF_CTRL2: s_next.romDis = hostData[dl_pkg::HRD_BIT];
               default: ;
            endcase
         end
         if (rdEdge) begin
            case (hostAddr)
               dl_pkg::OFF_ADDR_LO: s_next.rdata = s_reg.addr[7:0];
               dl_pkg::OFF_ADDR_HI: s_next.rdata = s_reg.addr[15:8];
               dl_pkg::OFF_INT_LO: s_next.rdata = s_reg.intReg[7:0];
               dl_pkg::OFF_INT_HI: s_next.rdata = s_reg.intReg[15:8];
               default: s_next.rdata = 8'h00;
            endcase
            if (hostAddr == dl_pkg::OFF_DATAINC_HI) begin
               s_next.addr = accAddr + 16'h0002;
            end
         end
      end
      s_next.dlAct = (s_next.mode == dl_pkg::ST_DOWNLOAD) || (s_next.mode == dl_pkg::ST_BUSY);
      s_next.busy = (s_next.mode == dl_pkg::ST_BUSY);
      // Window decode registered with the address so both change on one edge
      s_next.romSel = (s_next.memA >= dl_pkg::ROM_LO) && !s_next.romDis;
      s_next.dramSel = (s_next.memA < dl_pkg::ROM_LO) || s_next.romDis;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.rstSync <= 3'h0;
         s_reg.mode <= dl_pkg::ST_DIAG;
         s_reg.winCnt <= 17'h00000;
      end else begin
         s_reg <= s_next;
      end
   end

   assign ioRdata = s_reg.rdata;
   assign memWrite = s_reg.memWr;
   assign memAddr = s_reg.memA;
   assign memWdata = s_reg.memD;
   assign handlerRomSelect = s_reg.romSel;
   assign dramSelect = s_reg.dramSel;
   assign handler_rom_disable = s_reg.romDis;
   assign downloadActive = s_reg.dlAct;
   assign cmdBusy = s_reg.busy;
   assign runTarget = s_reg.run;
   assign targetEntry = s_reg.entry;
endmodule
`default_nettype wire

//--- tb/dl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dl_assertions #(
   parameter int REQ_WINDOW = 200, // Request window
   parameter int DIAG_TIME = 10 // Diag cycles
) (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic system_reset_n, // Host reset
   input wire logic ioWrite, // Write strobe
   input wire logic [3:0] ioAddr, // Offset
   input wire logic [7:0] ioWdata, // Write data
   input wire logic memWrite, // RAM write
   input wire logic [15:0] memAddr, // RAM address
   input wire logic handlerRomSelect, // ROM select
   input wire logic dramSelect, // DRAM select
   input wire logic handler_rom_disable, // ROM off
   input wire logic downloadActive, // Download
   input wire logic cmdBusy, // Busy
   input wire logic runTarget // Running
);
   logic [9:0] busyCnt_reg;
   logic [9:0] busyCnt_next;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   always_comb busyCnt_next = cmdBusy ? busyCnt_reg + 10'h001 : 10'h000;
   always_ff @(posedge clk) busyCnt_reg <= rst ? 10'h000 : busyCnt_next;
   property p_len;
      $fell(cmdBusy) |-> busyCnt_reg inside {10'h15E, 10'h1C2, 10'h258};
   endproperty
   a_len: assert property (p_len) else $error("command length off");
   property p_start;
      $rose(ioWrite) && ioAddr == dl_pkg::OFF_INT_HI && ioWdata == dl_pkg::CMD_WRITE
         && downloadActive && !cmdBusy && !runTarget |-> ##[1:6] cmdBusy;
   endproperty
   a_start: assert property (p_start) else $error("command not started");
   property p_run;
      $rose(runTarget) |-> busyCnt_reg == 10'h258 || $past(busyCnt_reg) == 10'h258;
   endproperty
   a_run: assert property (p_run) else $error("run not after execute");
   property p_rom;
      $stable(memAddr) && $stable(handler_rom_disable) && memAddr >= dl_pkg::ROM_LO
         |-> dramSelect == handler_rom_disable && handlerRomSelect != handler_rom_disable;
   endproperty
   a_rom: assert property (p_rom) else $error("top window decode wrong");
   property p_pulse;
      memWrite |=> !memWrite;
   endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse too long");
   property p_rst;
      $past(rst) |-> !downloadActive && !cmdBusy && !runTarget && !handler_rom_disable;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared");
   property p_system_reset_n;
      !system_reset_n [*6] |-> !handler_rom_disable && !runTarget;
   endproperty
   a_system_reset_n: assert property (p_system_reset_n) else $error("host reset ignored");
   property p_dl;
      $rose(downloadActive) |-> !runTarget && !cmdBusy;
   endproperty
   a_dl: assert property (p_dl) else $error("download entry dirty");
endmodule
`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input wire logic clk, // Clock
   output logic system_reset_n, // Reset pin
   output logic ioWrite, // Write strobe
   output logic ioRead, // Read strobe
   output logic [3:0] ioAddr, // Offset
   output logic [7:0] ioWdata, // Data
   input wire logic [7:0] ioRdata // Read data
);
   initial begin
      system_reset_n = 1'b1;
      ioWrite = 1'b0;
      ioRead = 1'b0;
      ioAddr = 4'h0;
      ioWdata = 8'h00;
   end
   // Lines are inverted after release so stale values never look valid
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(posedge clk);
      #1;
      ioAddr = a;
      ioWdata = d;
      ioWrite = w;
      ioRead = !w;
      repeat (5) @(posedge clk);
      q = ioRdata;
      #1;
      ioWrite = 1'b0;
      ioRead = 1'b0;
      ioAddr = ~a;
      ioWdata = ~d;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic hw_reset();
      @(posedge clk);
      #1;
      system_reset_n = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      system_reset_n = 1'b1;
   endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int DIAG = 10;
   logic clk;
   logic rst;
   logic system_reset_n;
   logic ioWrite;
   logic ioRead;
   logic [3:0] ioAddr;
   logic [7:0] ioWdata;
   logic [7:0] ioRdata;
   logic [15:0] memAddr;
   logic [15:0] memWdata;
   logic handlerRomSelect;
   logic dramSelect;
   logic handler_rom_disable;
   logic downloadActive;
   logic cmdBusy;
   logic runTarget;
   logic [15:0] targetEntry;
   logic [15:0] w;
   logic memWrite;
   int wrCount = 0;
   int err_count = 0;
   int checks_done = 0;
   int seed = 32'hcfb0;
   adapter_code_download_entry #(.REQ_WINDOW(200), .DIAG_TIME(DIAG))
      adapter_code_download_entry_inst (.clk, .rst, .system_reset_n, .ioWrite, .ioRead,
      .ioAddr, .ioWdata, .ioRdata, .memWrite, .memAddr, .memWdata, .handlerRomSelect,
      .dramSelect, .handler_rom_disable, .downloadActive, .cmdBusy, .runTarget, .targetEntry);
   host_model host_model_inst (.clk, .system_reset_n, .ioWrite, .ioRead, .ioAddr, .ioWdata,
      .ioRdata);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Counts RAM write pulses so a fill's total write count can be checked against its word count
   always @(posedge clk) begin
      if (memWrite === 1'b1) begin
         wrCount++;
      end
   end
   function automatic int cycles(input logic [7:0] c);
      return (c == dl_pkg::CMD_STEP ? dl_pkg::STEP_US : c == dl_pkg::CMD_WRITE ?
         dl_pkg::WRITE_US : dl_pkg::EXEC_US) * dl_pkg::CLK_MHZ;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      host_model_inst.acc(1'b1, a, d, q);
   endtask
   task automatic wr16(input logic [3:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(a + 4'h1, d[15:8]);
   endtask
   task automatic rd16(input logic [3:0] a, output logic [15:0] v);
      host_model_inst.acc(1'b0, a, 8'h00, v[7:0]);
      host_model_inst.acc(1'b0, a + 4'h1, 8'h00, v[15:8]);
   endtask
   task automatic fill(input logic [15:0] v);
      wr16(dl_pkg::OFF_ADDR_LO, 16'h0800);
      wrCount = 0;
      repeat (1024) wr16(dl_pkg::OFF_DATAINC_LO, v);
      chk(memAddr, 16'h0FFE, "fill end");
      chk(memWdata, v, "fill data");
      chk(16'(wrCount), 16'h0400, "fill writes");
      $display("test fill %h done", v);
   endtask
   task automatic cmd(input logic [7:0] c);
      int n;
      wr(dl_pkg::OFF_INT_HI, c);
      chk({15'h0000, cmdBusy}, 16'h0001, "busy");
      n = 0;
      while (cmdBusy === 1'b1 && n < 700) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(n <= cycles(c)), 16'h0001, "cmd time");
      $display("test command %h done", c);
   endtask
   initial begin
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      rst = 1'b0;
      host_model_inst.hw_reset();
      repeat (DIAG + 8) @(posedge clk);
      rd16(dl_pkg::OFF_INT_LO, w);
      chk(w, dl_pkg::INT_DIAG_OK, "diag");
      fill(16'hAA55);
      rd16(dl_pkg::OFF_ADDR_LO, w);
      chk(w, 16'h1000, "addr");
      host_model_inst.hw_reset();
      repeat (DIAG + 8) @(posedge clk);
      wr16(dl_pkg::OFF_INT_LO, dl_pkg::INT_DL_REQ);
      repeat (20) @(posedge clk);
      rd16(dl_pkg::OFF_INT_LO, w);
      chk(w, 16'h0000, "enter");
      chk({15'h0000, downloadActive}, 16'h0001, "dl");
      fill(16'h0000);
      cmd(dl_pkg::CMD_WRITE);
      wr16(dl_pkg::OFF_ADDR_LO, 16'h0000);
      wr16(dl_pkg::OFF_DATA_LO, 16'h0A00);
      chk(targetEntry, 16'h0A00, "entry");
      wr16(dl_pkg::OFF_ADDR_LO, 16'h0600);
      for (int i = 0; i < 4; i++) begin
         w = 16'($random(seed));
         wr16(dl_pkg::OFF_DATAINC_LO, w);
         chk(memWdata, w, "code");
         chk(memAddr, 16'h0600 + 16'(2 * i), "waddr");
      end
      // A read through the autoincrement port must advance the address too
      rd16(dl_pkg::OFF_DATAINC_LO, w);
      rd16(dl_pkg::OFF_ADDR_LO, w);
      chk(w, 16'h060A, "read advance");
      cmd(dl_pkg::CMD_STEP);
      for (int r = 0; r < 2; r++) begin
         if (r == 1) wr(dl_pkg::OFF_CTRL2, 8'(1 << dl_pkg::HRD_BIT));
         wr16(dl_pkg::OFF_ADDR_LO, r == 1 ? dl_pkg::ROM_LO : dl_pkg::ROM_HI);
         wr16(dl_pkg::OFF_DATAINC_LO, 16'($random(seed)));
         chk({14'h0000, handlerRomSelect, dramSelect}, r == 1 ? 16'h1 : 16'h2, "map");
         chk({15'h0000, handler_rom_disable}, 16'(r), "rom off");
      end
      cmd(dl_pkg::CMD_EXECUTE);
      repeat (2) @(posedge clk);
      #1;
      chk({15'h0000, runTarget}, 16'h0001, "run");
      summarize();
   end
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      $display("wrong value at %0t: timeout", $time);
      summarize();
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
endmodule
bind adapter_code_download_entry dl_assertions #(.REQ_WINDOW(REQ_WINDOW),
   .DIAG_TIME(DIAG_TIME)) dl_assertions_inst (.clk, .rst, .system_reset_n, .ioWrite,
   .ioAddr, .ioWdata, .memWrite, .memAddr, .handlerRomSelect, .dramSelect,
   .handler_rom_disable, .downloadActive, .cmdBusy, .runTarget);
`default_nettype wire
